// ==== src/omcc_consts.svh ====
// Constants of the operating mode clock controller: register layout,
// reset values and oscillator cycle counts.
// Assumes it is included by its bare name from the design files.
`ifndef OMCC_CONSTS_SVH
`define OMCC_CONSTS_SVH

// ----------------------------------------------------------------
// Oscillator mode register layout.
// ----------------------------------------------------------------
`define OMCC_REG_RESET 8'h00
`define OMCC_BIT_STOP 1
`define OMCC_BIT_SLOW 2
`define OMCC_FIELD_LO 3
`define OMCC_FIELD_HI 4
`define OMCC_MODE_NORMAL 2'h0
`define OMCC_MODE_SLEEP 2'h1
`define OMCC_MODE_GREEN 2'h2

// ----------------------------------------------------------------
// Counts of oscillator cycles.
// ----------------------------------------------------------------
`define OMCC_WARM_LONG 12'h0800
`define OMCC_WARM_SHORT 12'h0020
`define OMCC_CFG_COUNT 12'h0800
`define OMCC_SLOW_DIV_LAST 2'h3

`endif

// ==== src/omcc_ctrl.sv ====
// Operating mode and clock gating controller of an 8-bit microcontroller.
// Assumes oscillator clocks and port pins arrive unsynchronised, and that
// the CPU writes the oscillator mode register on clk.
//
// What this block does
// [R01] Reset release holds execution for 2048 fast cycles.
// [R02] Crystal wake from power down counts 2048.
// [R03] RC-type wake from power down counts 32.
// [R04] Reset release enters normal mode, fast clock.
// [R05] Normal mode: fast clock, both oscillators run.
// [R06] Slow select bit picks slow or normal.
// [R07] Slow mode instruction clock is slow RC/4.
// [R08] Slow mode leaves fast oscillator to stop bit.
// [R09] Slow mode: slow RC runs, execution continues.
// [R10] Sleep request write enters power down from normal or slow mode.
// [R11] Power down stops all oscillators and execution.
// [R12] Port changes wake; port 1 gated by enables.
// [R13] Power down wakes into normal mode, or slow if slow bit set.
// [R14] Wake from power down clears sleep request.
// [R15] Green wake returns to the entering mode.
// [R16] Wake timer follows per-mode table; watchdog follows its option in every mode.
// [R17] Fast stop in normal mode acts as power down.
// [R18] Power-on waits 2048 slow RC cycles first.
// [R19] Interrupt and wake sources gated per mode.
// [R20] Register: stop bit1, slow bit2, mode 4:3.
// [R21] Mode field: 00 normal, 01 sleep, 10 green.
// [R22] Stop bit gates the selected fast oscillator.
// [R23] Green request enters green, cleared on wake.
`timescale 1ns/10ps
`include "omcc_consts.svh"
module omcc_ctrl (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic fast_osc_clk,
  input wire logic slow_rc_clk,
  input wire logic reset_source_hold,
  input wire logic fast_osc_is_rc,
  input wire logic internal_fast_rc_sel,
  input wire logic watchdog_option,
  input wire logic osc_mode_wr,
  input wire logic [7:0] osc_mode_wdata,
  input wire logic [7:0] port0_pins,
  input wire logic [7:0] port1_pins,
  input wire logic [7:0] port1_wake_enable,
  input wire logic wake_timer_enable,
  input wire logic wake_timer_overflow,
  output logic [7:0] osc_mode_register,
  output logic external_fast_osc_en,
  output logic internal_fast_rc_en,
  output logic internal_slow_rc_en,
  output logic cpu_run,
  output logic cpu_tick,
  output logic sys_clk_slow,
  output logic wake_timer_active,
  output logic watchdog_active,
  output logic internal_int_en,
  output logic timer_int_only,
  output logic external_int_en
);

  // ----------------------------------------------------------------
  // Decoding helpers.
  // ----------------------------------------------------------------
  // True in the states where the CPU executes instructions.
  function automatic logic is_run(input omcc_pkg::omcc_state_e s);
    is_run = (s == omcc_pkg::OMCC_NORMAL) || (s == omcc_pkg::OMCC_SLOW);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------
  // Bit 18 reset source, 17 slow RC, 16 fast osc, 15:8 port 1, 7:0 port 0.
  localparam int SYNC_W = 19;
  logic [SYNC_W-1:0] pins_raw; // Unsynchronised pin vector.
  logic [SYNC_W-1:0] sync_a;   // First stage, read only by the second.
  logic [SYNC_W-1:0] sync_b;   // Second stage, safe to use.
  logic [SYNC_W-1:0] sync_c;   // Previous safe value for edge detection.

  assign pins_raw = {reset_source_hold, slow_rc_clk, fast_osc_clk, port1_pins, port0_pins};

  // Each pin gets its own two-stage chain plus a history stage.
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (reset) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
          sync_c[gi] <= 1'b0;
        end else if (ce) begin
          sync_a[gi] <= pins_raw[gi];
          sync_b[gi] <= sync_a[gi];
          sync_c[gi] <= sync_b[gi];
        end
      end
    end
  endgenerate

  // Oscillator edges are sampled, so clk must run well above both of them.
  logic fast_edge;       // Fast oscillator rising edge.
  logic slow_edge;       // Slow RC rising edge.
  logic rst_src;         // Some reset source is still asserted.
  logic [7:0] p0_change; // Level change on port 0.
  logic [7:0] p1_change; // Level change on port 1.
  logic port_wake;       // Any enabled port change.
  logic green_wake;      // Any green mode wake source.

  assign fast_edge = sync_b[16] & ~sync_c[16];
  assign slow_edge = sync_b[17] & ~sync_c[17];
  assign rst_src = sync_b[18];
  assign p0_change = sync_b[7:0] ^ sync_c[7:0];
  assign p1_change = sync_b[15:8] ^ sync_c[15:8];
  assign port_wake = (|p0_change) | (|(p1_change & port1_wake_enable)); // see [R12]
  assign green_wake = port_wake | (wake_timer_enable & wake_timer_overflow); // see [R19]

  // ----------------------------------------------------------------
  // Warm-up counter.
  // ----------------------------------------------------------------
  omcc_warm_if warm ();

  assign warm.fast_edge = fast_edge;
  assign warm.slow_edge = slow_edge;

  omcc_warm_counter u_warm (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .w(warm.cnt)
  );

  // A done left over from the previous count is ignored while start is high.
  logic warm_done; // The count started on entry to this state finished.
  assign warm_done = warm.done & ~warm.start;

  // ----------------------------------------------------------------
  // Register write decoding.
  // ----------------------------------------------------------------
  omcc_pkg::omcc_state_e state;      // Current operating state.
  omcc_pkg::omcc_state_e next_state; // State after this cycle.
  logic wr_ok;                       // Write accepted: CPU is running.
  logic [1:0] wr_field;              // Written mode field, reserved as normal.
  logic [7:0] eff_reg;               // Register value seen this cycle.
  logic next_start;                  // Start a count next cycle.
  logic next_long;                   // Length of that count.
  logic next_use_slow;               // Source of that count.

  // Writes only arrive while executing; reserved code 11 is written as normal.
  always_comb begin
    wr_ok = osc_mode_wr & is_run(state);
    wr_field = osc_mode_wdata[`OMCC_FIELD_HI:`OMCC_FIELD_LO];
    if (wr_field == 2'h3) begin
      wr_field = `OMCC_MODE_NORMAL; // see [R21]
    end
    eff_reg = osc_mode_register;
    if (wr_ok) begin
      eff_reg = {3'h0, wr_field, osc_mode_wdata[`OMCC_BIT_SLOW:`OMCC_BIT_STOP], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_start = 1'b0;
    next_long = 1'b1;
    next_use_slow = 1'b0;
    if (rst_src && state != omcc_pkg::OMCC_CFG) begin
      // Restart the long warm-up every cycle until the source lets go.
      next_state = omcc_pkg::OMCC_WARM; // see [R01]
      next_start = 1'b1;
    end else begin
      unique case (state)
        omcc_pkg::OMCC_CFG: begin
          if (warm_done) begin
            next_state = omcc_pkg::OMCC_WARM; // see [R18]
            next_start = 1'b1;
          end
        end
        omcc_pkg::OMCC_WARM: begin
          if (warm_done) begin
            next_state = omcc_pkg::OMCC_NORMAL; // see [R04]
          end
        end
        omcc_pkg::OMCC_NORMAL, omcc_pkg::OMCC_SLOW: begin
          if (eff_reg[`OMCC_FIELD_HI:`OMCC_FIELD_LO] == `OMCC_MODE_SLEEP) begin
            next_state = omcc_pkg::OMCC_PDOWN; // see [R10]
          end else if (eff_reg[`OMCC_FIELD_HI:`OMCC_FIELD_LO] == `OMCC_MODE_GREEN) begin
            next_state = omcc_pkg::OMCC_GREEN; // see [R23]
          end else if (eff_reg[`OMCC_BIT_STOP] && !eff_reg[`OMCC_BIT_SLOW]) begin
            // Fast source stopped with nothing else to clock the CPU.
            next_state = omcc_pkg::OMCC_PDOWN; // see [R17]
          end else if (eff_reg[`OMCC_BIT_SLOW]) begin
            next_state = omcc_pkg::OMCC_SLOW; // see [R06]
          end else begin
            next_state = omcc_pkg::OMCC_NORMAL; // see [R06]
          end
        end
        omcc_pkg::OMCC_PDOWN: begin
          if (port_wake) begin
            next_state = omcc_pkg::OMCC_WARM; // see [R13]
            next_start = 1'b1;
            next_long = ~fast_osc_is_rc; // see [R02] see [R03]
          end
        end
        omcc_pkg::OMCC_GREEN: begin
          // No warm-up is counted on wake, even where the stop bit stopped the fast clock in green.
          if (green_wake) begin
            if (osc_mode_register[`OMCC_BIT_SLOW]) begin
              next_state = omcc_pkg::OMCC_SLOW; // see [R15]
            end else begin
              next_state = omcc_pkg::OMCC_NORMAL; // see [R15]
            end
          end
        end
      endcase
    end
  end

  // State register; power-on starts with the configuration wait.
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= omcc_pkg::OMCC_CFG;
      warm.start <= 1'b1;
      warm.long_len <= 1'b1;
      warm.use_slow <= 1'b1; // see [R18]
    end else if (ce) begin
      state <= next_state;
      warm.start <= next_start;
      if (next_start) begin
        warm.long_len <= next_long;
        warm.use_slow <= next_use_slow;
      end
    end
  end

  // ----------------------------------------------------------------
  // Oscillator mode register.
  // ----------------------------------------------------------------
  // The CPU is stopped whenever a wake clears a bit, so a write and such a
  // clear can never meet in one cycle; a reset source clear wins over a write.
  always_ff @(posedge clk) begin
    if (reset || rst_src) begin
      osc_mode_register <= `OMCC_REG_RESET; // see [R20]
    end else if (ce) begin
      if (wr_ok) begin
        osc_mode_register <= eff_reg; // see [R20]
      end else if (state == omcc_pkg::OMCC_PDOWN && port_wake) begin
        osc_mode_register[`OMCC_FIELD_LO] <= 1'b0; // see [R14]
        // Waking from the no-clock case must restart the fast source.
        if (!osc_mode_register[`OMCC_BIT_SLOW]) begin
          osc_mode_register[`OMCC_BIT_STOP] <= 1'b0; // see [R17]
        end
      end else if (state == omcc_pkg::OMCC_GREEN && green_wake) begin
        osc_mode_register[`OMCC_FIELD_HI] <= 1'b0; // see [R23]
      end
    end
  end

  // ----------------------------------------------------------------
  // Slow instruction clock divider.
  // ----------------------------------------------------------------
  logic [1:0] slow_div; // Slow RC edges within one instruction.

  always_ff @(posedge clk) begin
    if (reset) begin
      slow_div <= 2'h0;
    end else if (ce) begin
      if (state != omcc_pkg::OMCC_SLOW) begin
        slow_div <= 2'h0;
      end else if (slow_edge) begin
        slow_div <= slow_div + 2'h1; // see [R07]
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered gating outputs.
  // ----------------------------------------------------------------
  logic fast_on; // Selected fast oscillator should run.

  // The fast source runs through configuration and warm-up, always in
  // normal mode, and by the stop bit in slow and green modes.
  always_comb begin
    unique case (state)
      omcc_pkg::OMCC_SLOW, omcc_pkg::OMCC_GREEN: begin
        fast_on = ~osc_mode_register[`OMCC_BIT_STOP]; // see [R08] see [R09]
      end
      omcc_pkg::OMCC_PDOWN: begin
        fast_on = 1'b0; // see [R11]
      end
      default: begin
        fast_on = 1'b1; // see [R05]
      end
    endcase
  end

  // Oscillator enables and the CPU run and tick strobes.
  always_ff @(posedge clk) begin
    if (reset) begin
      external_fast_osc_en <= 1'b0;
      internal_fast_rc_en <= 1'b0;
      internal_slow_rc_en <= 1'b0;
      cpu_run <= 1'b0;
      cpu_tick <= 1'b0;
      sys_clk_slow <= 1'b0;
    end else if (ce) begin
      external_fast_osc_en <= fast_on & ~internal_fast_rc_sel; // see [R22]
      internal_fast_rc_en <= fast_on & internal_fast_rc_sel; // see [R22]
      internal_slow_rc_en <= state != omcc_pkg::OMCC_PDOWN; // see [R11]
      cpu_run <= is_run(state); // see [R01] see [R09]
      sys_clk_slow <= osc_mode_register[`OMCC_BIT_SLOW] & (state != omcc_pkg::OMCC_PDOWN);
      if (state == omcc_pkg::OMCC_NORMAL) begin
        cpu_tick <= fast_edge; // see [R05]
      end else if (state == omcc_pkg::OMCC_SLOW) begin
        cpu_tick <= slow_edge && slow_div == `OMCC_SLOW_DIV_LAST; // see [R07]
      end else begin
        cpu_tick <= 1'b0;
      end
    end
  end

  // Peripheral and interrupt gating per mode.
  always_ff @(posedge clk) begin
    if (reset) begin
      wake_timer_active <= 1'b0;
      watchdog_active <= 1'b0;
      internal_int_en <= 1'b0;
      timer_int_only <= 1'b0;
      external_int_en <= 1'b0;
    end else if (ce) begin
      wake_timer_active <= wake_timer_enable
        & (is_run(state) | (state == omcc_pkg::OMCC_GREEN)); // see [R16]
      watchdog_active <= watchdog_option; // see [R16]
      internal_int_en <= is_run(state); // see [R19]
      timer_int_only <= state == omcc_pkg::OMCC_GREEN; // see [R19]
      external_int_en <= is_run(state) | (state == omcc_pkg::OMCC_GREEN); // see [R19]
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  warm_hold_a: assert property (@(posedge clk) disable iff (reset) // see [R01]
    ce && state == omcc_pkg::OMCC_WARM |=> !cpu_run)
    else $error("CPU ran during warm-up.");

  wake_length_a: assert property (@(posedge clk) disable iff (reset) // see [R02]
    ce && state == omcc_pkg::OMCC_PDOWN && port_wake && !rst_src
    |=> state == omcc_pkg::OMCC_WARM && warm.start && warm.long_len == !fast_osc_is_rc)
    else $error("Wrong warm-up length after power down.");

  normal_osc_a: assert property (@(posedge clk) disable iff (reset) // see [R05]
    ce && state == omcc_pkg::OMCC_NORMAL
    |=> internal_slow_rc_en && (external_fast_osc_en || internal_fast_rc_en))
    else $error("Oscillator off in normal mode.");

  slow_tick_a: assert property (@(posedge clk) disable iff (reset) // see [R07]
    ce && $past(state) == omcc_pkg::OMCC_SLOW && cpu_tick |-> $past(slow_div) == 2'h3)
    else $error("Slow tick not on the fourth edge.");

  sleep_entry_a: assert property (@(posedge clk) disable iff (reset) // see [R10]
    ce && wr_ok && !rst_src && wr_field == `OMCC_MODE_SLEEP
    |=> state == omcc_pkg::OMCC_PDOWN)
    else $error("Sleep request did not enter power down.");

  pdown_osc_a: assert property (@(posedge clk) disable iff (reset) // see [R11]
    ce && state == omcc_pkg::OMCC_PDOWN
    |=> !internal_slow_rc_en && !external_fast_osc_en && !internal_fast_rc_en && !cpu_run)
    else $error("Activity left on in power down.");

  sleep_clear_a: assert property (@(posedge clk) disable iff (reset) // see [R14]
    ce && state == omcc_pkg::OMCC_PDOWN && port_wake && !rst_src
    |=> osc_mode_register[3] == 1'b0 ##1 state != omcc_pkg::OMCC_PDOWN)
    else $error("Sleep request not cleared on wake.");

  green_return_a: assert property (@(posedge clk) disable iff (reset) // see [R15]
    ce && state == omcc_pkg::OMCC_GREEN && green_wake && !rst_src
    |=> state == ($past(osc_mode_register[2]) ? omcc_pkg::OMCC_SLOW : omcc_pkg::OMCC_NORMAL))
    else $error("Green wake returned to the wrong mode.");

  no_clock_a: assert property (@(posedge clk) disable iff (reset) // see [R17]
    ce && state == omcc_pkg::OMCC_NORMAL && !rst_src
    && eff_reg[4:1] == 4'h1 |=> state == omcc_pkg::OMCC_PDOWN)
    else $error("Stopped fast clock did not act as power down.");

endmodule // omcc_ctrl

// ==== src/omcc_pkg.sv ====
// Types of the operating mode clock controller.
// Assumes nothing of its surroundings.
package omcc_pkg;

  // Controller states, one-hot.
  typedef enum logic [5:0] {
    OMCC_CFG = 6'h01,
    OMCC_WARM = 6'h02,
    OMCC_NORMAL = 6'h04,
    OMCC_SLOW = 6'h08,
    OMCC_GREEN = 6'h10,
    OMCC_PDOWN = 6'h20
  } omcc_state_e;

endpackage

// ==== src/omcc_warm_counter.sv ====
// Oscillator cycle counter for warm-up and configuration waits.
// Assumes edge strobes already synchronised to clk by the controller.
`timescale 1ns/10ps
`include "omcc_consts.svh"
module omcc_warm_counter (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  omcc_warm_if.cnt w
);

  // ----------------------------------------------------------------
  // Count selection.
  // ----------------------------------------------------------------
  logic [11:0] cnt;    // Oscillator edges counted so far.
  logic busy;          // A count is running.
  logic tick;          // Edge of the selected oscillator.
  logic [11:0] target; // Number of edges to count.

  // The selected source and length only change together with start.
  always_comb begin
    tick = w.use_slow ? w.slow_edge : w.fast_edge;
    if (w.use_slow) begin
      target = `OMCC_CFG_COUNT;
    end else if (w.long_len) begin
      target = `OMCC_WARM_LONG;
    end else begin
      target = `OMCC_WARM_SHORT;
    end
  end

  // ----------------------------------------------------------------
  // Counter.
  // ----------------------------------------------------------------
  // A start always restarts, so a reset source held high keeps it at zero.
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt <= 12'h0000;
      busy <= 1'b0;
      w.done <= 1'b0;
    end else if (ce) begin
      if (w.start) begin
        cnt <= 12'h0000;
        busy <= 1'b1;
        w.done <= 1'b0;
      end else if (busy && tick) begin
        if (cnt + 12'h0001 == target) begin
          busy <= 1'b0;
          w.done <= 1'b1;
        end
        cnt <= cnt + 12'h0001;
      end
    end
  end

endmodule // omcc_warm_counter

// ==== src/omcc_warm_if.sv ====
// Link between the mode controller and its oscillator cycle counter.
// Assumes both ends run on the same clock and clock enable.
`timescale 1ns/10ps
interface omcc_warm_if;
  logic start;     // Starts a new count, one cycle.
  logic long_len;  // Count 2048 rather than 32 fast cycles.
  logic use_slow;  // Count slow RC cycles for the configuration wait.
  logic fast_edge; // One rising edge of the fast oscillator seen.
  logic slow_edge; // One rising edge of the slow RC seen.
  logic done;      // Count finished; holds until the next start.
  modport ctrl (output start, long_len, use_slow, fast_edge, slow_edge, input done);
  modport cnt (input start, long_len, use_slow, fast_edge, slow_edge, output done);
endinterface // omcc_warm_if

// ==== tb/omcc_ctrl_tb_top.sv ====
// Testbench of the mode controller: boot, mode changes, wakes, warm-ups.
// Assumes the oscillator model drives both oscillator pins.
`timescale 1ns/10ps
module omcc_ctrl_tb_top;
  localparam int PER = 6; // Clk cycles per oscillator period.
  localparam int LIMIT = 98000; // Whole run is about 87000 cycles.
  logic clk = 1'b0, reset = 1'b1, ce = 1'b1, reset_source_hold = 1'b0;
  logic fast_osc_is_rc = 1'b0, internal_fast_rc_sel = 1'b0;
  logic watchdog_option = 1'b1, osc_mode_wr = 1'b0, wake_timer_enable = 1'b1;
  logic wake_timer_overflow = 1'b0, fast_osc_clk, slow_rc_clk;
  logic [7:0] osc_mode_wdata = 8'h00, port0_pins = 8'h00, port1_pins = 8'h00;
  logic [7:0] port1_wake_enable = 8'h02, osc_mode_register;
  logic external_fast_osc_en, internal_fast_rc_en, internal_slow_rc_en;
  logic cpu_run, cpu_tick, sys_clk_slow, wake_timer_active, watchdog_active;
  logic internal_int_en, timer_int_only, external_int_en;
  int mismatches = 0, checked = 0, cycles = 0, ticks;

  omcc_ctrl uut (.clk, .reset, .ce, .fast_osc_clk, .slow_rc_clk,
    .reset_source_hold, .fast_osc_is_rc, .internal_fast_rc_sel,
    .watchdog_option, .osc_mode_wr, .osc_mode_wdata, .port0_pins,
    .port1_pins, .port1_wake_enable, .wake_timer_enable,
    .wake_timer_overflow, .osc_mode_register, .external_fast_osc_en,
    .internal_fast_rc_en, .internal_slow_rc_en, .cpu_run, .cpu_tick,
    .sys_clk_slow, .wake_timer_active, .watchdog_active, .internal_int_en,
    .timer_int_only, .external_int_en);

  omcc_osc_model osc (.clk, .fast_en(external_fast_osc_en | internal_fast_rc_en),
    .slow_en(internal_slow_rc_en), .fast_osc_clk, .slow_rc_clk);

  always #4 clk = ~clk;

  // A hang is cut short here and counted as a mismatch.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Access tasks.
  // ----------------------------------------------------------------
  function automatic logic [7:0] b(input logic x);
    return {7'h00, x};
  endfunction
  // Sampling 1 ns after the edge keeps clear of its updates.
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle CPU write, then time for the new mode to show.
  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    osc_mode_wr <= 1'b1;
    osc_mode_wdata <= d;
    @(posedge clk);
    osc_mode_wr <= 1'b0;
    idle(3);
  endtask
  // Waits for execution and checks the delay against a nominal count.
  task automatic wait_run(input string what, input int nom);
    int n;
    n = 0;
    while (cpu_run !== 1'b1 && n < 40000) begin
      idle(1);
      n++;
    end
    chk(what, 8'h01, b(n >= nom - 12 && n <= nom + 60));
  endtask
  task automatic ovf();
    @(posedge clk) wake_timer_overflow <= 1'b1;
    @(posedge clk) wake_timer_overflow <= 1'b0;
    idle(6);
  endtask
  task automatic boot(input logic rc);
    @(posedge clk);
    reset <= 1'b1;
    fast_osc_is_rc <= rc;
    internal_fast_rc_sel <= rc;
    idle(10);
    chk("reg_reset", 8'h00, osc_mode_register);
    chk("run_reset", 8'h00, b(cpu_run));
    @(posedge clk) reset <= 1'b0;
    wait_run("boot_time", 4096 * PER);
  endtask
  task automatic tdone(input string name);
    $display("test %s done", name);
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial begin
    boot(1'b0);
    chk("reg", 8'h00, osc_mode_register);
    chk("slow_sel", 8'h00, b(sys_clk_slow));
    chk("fast_en", 8'h01, b(external_fast_osc_en));
    chk("slow_en", 8'h01, b(internal_slow_rc_en));
    chk("wdog", 8'h01, b(watchdog_active));
    chk("timer", 8'h01, b(wake_timer_active));
    chk("ints", 8'h01, b(internal_int_en & external_int_en & ~timer_int_only));
    tdone("boot");
    // Slow mode keeps the fast oscillator until software stops it.
    wr(8'h04);
    chk("slow_sel", 8'h01, b(sys_clk_slow));
    chk("fast_kept", 8'h01, b(external_fast_osc_en));
    ticks = 0;
    repeat (96) begin
      idle(1);
      ticks += (cpu_tick === 1'b1);
    end
    chk("ticks", 8'h04, ticks[7:0]);
    wr(8'h06);
    chk("fast_stop", 8'h00, b(external_fast_osc_en));
    chk("slow_run", 8'h01, b(internal_slow_rc_en & cpu_run));
    tdone("slow");
    // Green entered from slow, woken by the timer.
    wr(8'h16);
    chk("green_run", 8'h00, b(cpu_run));
    chk("green_ints", 8'h01, b(timer_int_only & external_int_en));
    ovf();
    chk("reg", 8'h06, osc_mode_register);
    chk("back_slow", 8'h01, b(sys_clk_slow & cpu_run));
    tdone("green_slow");
    wr(8'h00);
    chk("normal", 8'h01, b(external_fast_osc_en & ~sys_clk_slow));
    wr(8'h18);
    chk("reserved", 8'h00, osc_mode_register);
    // Power down: timer and disabled port 1 bits must not wake it.
    wr(8'h08);
    chk("pd_osc", 8'h00, b(cpu_run | external_fast_osc_en | internal_slow_rc_en));
    chk("pd_timer", 8'h00, b(wake_timer_active));
    chk("pd_ints", 8'h00, b(external_int_en | internal_int_en));
    @(posedge clk) watchdog_option <= 1'b0;
    idle(2);
    chk("pd_wdog", 8'h00, b(watchdog_active));
    ovf();
    chk("pd_ovf", 8'h00, b(cpu_run));
    @(posedge clk) port1_pins[0] <= 1'b1;
    idle(8);
    chk("pd_masked", 8'h00, b(cpu_run));
    @(posedge clk) port1_pins[1] <= 1'b1;
    wait_run("wake_xtal", 2048 * PER);
    chk("reg", 8'h00, osc_mode_register);
    chk("wake_normal", 8'h00, b(sys_clk_slow));
    tdone("power_down");
    // Green from normal, woken by a port 0 change.
    wr(8'h10);
    @(posedge clk) port0_pins[3] <= 1'b1;
    idle(8);
    chk("green_wake", 8'h01, b(cpu_run & ~sys_clk_slow));
    chk("reg", 8'h00, osc_mode_register);
    // Fast stop in normal mode leaves no clock.
    wr(8'h02);
    chk("noclk", 8'h00, b(cpu_run | external_fast_osc_en));
    @(posedge clk) port0_pins[3] <= 1'b0;
    wait_run("wake_noclk", 2048 * PER);
    tdone("green_noclk");
    // A held reset source restarts the long warm-up.
    @(posedge clk) reset_source_hold <= 1'b1;
    idle(8);
    chk("hold_run", 8'h00, b(cpu_run));
    @(posedge clk) reset_source_hold <= 1'b0;
    wait_run("hold_warm", 2048 * PER);
    tdone("hold");
    // Internal fast RC build: short wake warm-up.
    boot(1'b1);
    chk("rc_en", 8'h01, b(internal_fast_rc_en));
    wr(8'h08);
    @(posedge clk) port0_pins[0] <= 1'b1;
    wait_run("wake_rc", 32 * PER);
    tdone("rc_wake");
    test_done();
  end
endmodule // omcc_ctrl_tb_top

// ==== tb/omcc_osc_model.sv ====
// Model of the two oscillators that feed the mode controller.
// Assumes the enables come from the controller on clk.
`timescale 1ns/10ps
module omcc_osc_model (
  input wire logic clk,
  input wire logic fast_en,
  input wire logic slow_en,
  output logic fast_osc_clk,
  output logic slow_rc_clk
);
  // ----------------------------------------------------------------
  // Both run at clk/6, slow enough to pass the synchronisers.
  // ----------------------------------------------------------------
  logic [1:0] fast_cnt = 2'h0; // Cycles since the last fast toggle.
  logic [1:0] slow_cnt = 2'h0; // Cycles since the last slow toggle.
  initial begin
    fast_osc_clk = 1'b0;
    slow_rc_clk = 1'b0;
  end
  // A stopped oscillator parks low, so no stray edge reaches the counter.
  always @(posedge clk) begin
    if (!fast_en) begin
      fast_cnt <= 2'h0;
      fast_osc_clk <= 1'b0;
    end else if (fast_cnt == 2'h2) begin
      fast_cnt <= 2'h0;
      fast_osc_clk <= ~fast_osc_clk;
    end else begin
      fast_cnt <= fast_cnt + 2'h1;
    end
  end
  // The slow RC behaves the same way under its own enable.
  always @(posedge clk) begin
    if (!slow_en) begin
      slow_cnt <= 2'h0;
      slow_rc_clk <= 1'b0;
    end else if (slow_cnt == 2'h2) begin
      slow_cnt <= 2'h0;
      slow_rc_clk <= ~slow_rc_clk;
    end else begin
      slow_cnt <= slow_cnt + 2'h1;
    end
  end
endmodule // omcc_osc_model
